// ---- dv/rtcpit_sink.sv ----
// Event fabric model: counts the event pulses that the block sends out
`default_nettype none
module rtcpit_sink
  import rtcpit_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Event lines
  input wire rtcpit_pkg::rtcpit_evt_s events,
  // Counts
  output var int n_wrap,
  output var int n_match,
  output var int n_tap [8]
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      n_wrap <= 0;
      n_match <= 0;
      n_tap <= '{default: 0};
    end
    else
    begin
      if (events.wrap_event === 1'b1)
        n_wrap <= n_wrap + 1;
      if (events.match_event === 1'b1)
        n_match <= n_match + 1;
      for (int k = 0; k < 8; k++)
        if (events.tap[k] === 1'b1)
          n_tap[k] <= n_tap[k] + 1;
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench of the counter and interval timer block
`default_nettype none
module tb_top;
  import rtcpit_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  rtcpit_wb_req_s req = '0;
  rtcpit_wb_rsp_s rsp;
  logic lp = 1'b0;
  logic xt = 1'b0;
  logic ex = 1'b0;
  logic standby = 1'b0;
  logic halt = 1'b0;
  rtcpit_evt_s ev;
  logic cirq;
  logic iirq;
  int fails = 0;
  int comparisons = 0;
  int n_wrap;
  int n_match;
  int n_tap [8];
  int t [8];
  int a;
  int w0;
  int m0;
  int p;
  logic [1:0] src = 2'h0;
  logic [31:0] q;
  logic [31:0] d;
  logic [4:0] midx [15] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08,
    5'h0A, 5'h0C, 5'h10, 5'h11, 5'h12, 5'h13, 5'h15};
  logic [4:0] ridx [10] = '{IDX_MAIN_CONTROL, IDX_IRQ_ENABLE, IDX_STAGING, IDX_DEBUG_HALT,
    IDX_SOURCE_SELECT, IDX_WRAP_LIMIT, IDX_MATCH_VALUE, IDX_INTERVAL_CONTROL,
    IDX_INTERVAL_IRQ_EN, IDX_INTERVAL_DEBUG};
  logic [15:0] rmsk [10] = '{16'h00F9, 16'h0003, 16'h00FF, 16'h0001, 16'h0003, 16'hFFFF,
    16'hFFFF, 16'h0079, 16'h0001, 16'h0001};

  initial
  begin
    forever #25 mclk = ~mclk;
  end

  rtcpit_top i_rtcpit_top (.mclk(mclk), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp),
    .lowpower_osc(lp), .crystal_osc(xt), .ext_clock_pin(ex), .sleep_standby(standby),
    .debug_halt(halt), .events(ev), .counter_irq(cirq), .interval_irq(iirq));
  rtcpit_sink i_rtcpit_sink (.mclk(mclk), .rst_n(rst_n), .events(ev), .n_wrap(n_wrap),
    .n_match(n_match), .n_tap(n_tap));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %0t mismatch got %h expected %h", $time, g, e);
    end
  endtask

  // Classic single cycle, held until ack, one idle cycle after
  task automatic wb(input logic we, input logic [4:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: {idx, 2'b00}, dat: wd};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (rsp.ack !== 1'b1 && n < 50);
    q = rsp.dat;
    req <= '0;
    if (n >= 50)
    begin
      fails++;
      $display("ERROR %0t no bus answer", $time);
    end
  endtask

  task automatic wr(input logic [4:0] idx, input logic [31:0] wd);
    wb(1'b1, idx, wd);
  endtask

  task automatic rd(input logic [4:0] idx, input logic [31:0] e);
    wb(1'b0, idx, 32'h0);
    chk(q, e);
  endtask

  // Rising edges of the selected slow source, four mclk each (32 low-power pulses, 128 mclk, for the 1 kHz source)
  task automatic tick(input int n);
    repeat (n)
    begin
      repeat ((src == SRC_LOWPOWER_1K) ? 32 : 1)
      begin
        @(posedge mclk);
        if (src == SRC_CRYSTAL)
          xt <= 1'b1;
        else if (src == SRC_EXT_PIN)
          ex <= 1'b1;
        else
          lp <= 1'b1;
        repeat (2) @(posedge mclk);
        lp <= 1'b0;
        xt <= 1'b0;
        ex <= 1'b0;
        @(posedge mclk);
      end
    end
  endtask

  function automatic int nxt(input int c, input int n, input int lim);
    return (c + n) % (lim + 1);
  endfunction

  task automatic cnt_now();
    wb(1'b0, IDX_TICK_COUNTER, 32'h0);
    a = int'(q[15:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge mclk);
    fails++;
    results();
  end

  initial
  begin
    void'($urandom(34397));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (midx[i])
      rd(midx[i], 32'h0);
    rd(5'h06, 32'h0);
    wr(5'h09, 32'hFFFF);
    rd(5'h09, 32'h0);
    foreach (ridx[i])
    begin
      d = $urandom;
      wr(ridx[i], d);
      rd(ridx[i], d & {16'h0, rmsk[i]});
      if (ridx[i] == IDX_SOURCE_SELECT)
        src = d[1:0];
    end
    rd(IDX_SYNC_BUSY, 32'h0D);
    rd(IDX_INTERVAL_SYNC, 32'h1);
    tick(2);
    rd(IDX_SYNC_BUSY, 32'h0);
    rd(IDX_INTERVAL_SYNC, 32'h0);
    wr(IDX_SYNC_BUSY, 32'hFF);
    rd(IDX_SYNC_BUSY, 32'h0);
    wr(IDX_MAIN_CONTROL, 32'h0);
    wr(IDX_INTERVAL_CONTROL, 32'h0);
    tick(2);
    wr(IDX_TICK_COUNTER, 32'h2);
    rd(IDX_SYNC_BUSY, 32'h2);
    tick(2);
    rd(IDX_TICK_COUNTER, 32'h2);
    for (int s = 0; s < 4; s++)
    begin
      src = s[1:0];
      wr(IDX_SOURCE_SELECT, s);
      wr(IDX_MAIN_CONTROL, 32'h0);
      tick(2);
      wr(IDX_MATCH_VALUE, 32'h3);
      wr(IDX_WRAP_LIMIT, 32'h5);
      wr(IDX_IRQ_ENABLE, 32'h3);
      wr(IDX_MAIN_CONTROL, 32'h1);
      tick(2);
      wr(IDX_IRQ_FLAGS, 32'h3);
      cnt_now();
      w0 = n_wrap;
      m0 = n_match;
      tick(6);
      rd(IDX_TICK_COUNTER, nxt(a, 6, 5));
      rd(IDX_IRQ_FLAGS, 32'h3);
      chk(cirq, 1'b1);
      chk(n_wrap - w0, 1);
      chk(n_match - m0, 1);
      wr(IDX_IRQ_FLAGS, 32'h1);
      rd(IDX_IRQ_FLAGS, 32'h2);
      chk(cirq, 1'b1);
      wr(IDX_IRQ_FLAGS, 32'h2);
      @(posedge mclk);
      chk(cirq, 1'b0);
    end
    wr(IDX_IRQ_ENABLE, 32'h0);
    tick(6);
    rd(IDX_IRQ_FLAGS, 32'h3);
    chk(cirq, 1'b0);
    wr(IDX_IRQ_FLAGS, 32'h3);
    repeat (3)
    begin
      p = $urandom % 4;
      wr(IDX_MAIN_CONTROL, (p << 3) | 1);
      tick(2);
      cnt_now();
      tick(16);
      rd(IDX_TICK_COUNTER, nxt(a, 16 >> p, 5));
    end
    wr(IDX_MAIN_CONTROL, 32'h0);
    tick(2);
    cnt_now();
    tick(4);
    rd(IDX_TICK_COUNTER, a);
    standby <= 1'b1;
    wr(IDX_MAIN_CONTROL, 32'h1);
    tick(2);
    cnt_now();
    tick(3);
    rd(IDX_TICK_COUNTER, a);
    wr(IDX_MAIN_CONTROL, 32'h81);
    tick(2);
    cnt_now();
    tick(3);
    rd(IDX_TICK_COUNTER, nxt(a, 3, 5));
    halt <= 1'b1;
    wr(IDX_DEBUG_HALT, 32'h0);
    cnt_now();
    tick(3);
    rd(IDX_TICK_COUNTER, a);
    wr(IDX_DEBUG_HALT, 32'h1);
    cnt_now();
    tick(3);
    rd(IDX_TICK_COUNTER, nxt(a, 3, 5));
    halt <= 1'b0;
    wr(IDX_MAIN_CONTROL, 32'h0);
    wr(IDX_INTERVAL_CONTROL, 32'h08);
    wr(IDX_INTERVAL_IRQ_EN, 32'h1);
    wr(IDX_INTERVAL_CONTROL, 32'h09);
    rd(IDX_INTERVAL_SYNC, 32'h1);
    tick(2);
    wr(IDX_INTERVAL_FLAG, 32'h1);
    t = n_tap;
    tick(256);
    for (int k = 0; k < 8; k++)
      chk(n_tap[k] - t[k], (k < 5) ? 0 : 1 << (k - 5));
    rd(IDX_INTERVAL_FLAG, 32'h1);
    chk(iirq, 1'b1);
    wr(IDX_INTERVAL_FLAG, 32'h1);
    @(posedge mclk);
    chk(iirq, 1'b0);
    wr(IDX_INTERVAL_CONTROL, 32'h08);
    tick(2);
    t = n_tap;
    wr(IDX_INTERVAL_FLAG, 32'h1);
    tick(64);
    chk(n_tap[7] - t[7], 0);
    rd(IDX_INTERVAL_FLAG, 32'h0);
    results();
  end
endmodule
`default_nettype wire

// ---- rtl/rtcpit_pkg.sv ----
// Package: register map, field layout, reset values and carrier types of the RTC/interval block
`default_nettype none
package rtcpit_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [4:0] IDX_MAIN_CONTROL = 5'h00;
  localparam logic [4:0] IDX_SYNC_BUSY = 5'h01;
  localparam logic [4:0] IDX_IRQ_ENABLE = 5'h02;
  localparam logic [4:0] IDX_IRQ_FLAGS = 5'h03;
  localparam logic [4:0] IDX_STAGING = 5'h04;
  localparam logic [4:0] IDX_DEBUG_HALT = 5'h05;
  localparam logic [4:0] IDX_SOURCE_SELECT = 5'h07;
  localparam logic [4:0] IDX_TICK_COUNTER = 5'h08;
  localparam logic [4:0] IDX_WRAP_LIMIT = 5'h0A;
  localparam logic [4:0] IDX_MATCH_VALUE = 5'h0C;
  localparam logic [4:0] IDX_INTERVAL_CONTROL = 5'h10;
  localparam logic [4:0] IDX_INTERVAL_SYNC = 5'h11;
  localparam logic [4:0] IDX_INTERVAL_IRQ_EN = 5'h12;
  localparam logic [4:0] IDX_INTERVAL_FLAG = 5'h13;
  localparam logic [4:0] IDX_INTERVAL_DEBUG = 5'h15;

  // Field positions
  localparam int CTL_COUNT_ENABLE = 0;
  localparam int CTL_PRESC_LSB = 3;
  localparam int CTL_STANDBY_RUN = 7;
  localparam int ICTL_INTERVAL_ENABLE = 0;
  localparam int ICTL_PERIOD_LSB = 3;
  localparam int IRQ_WRAP = 0;
  localparam int IRQ_MATCH = 1;
  localparam int DBG_HALT_OVERRIDE = 0;

  // Sync slots; slots 0 to 3 are also the bit order of the busy register, slot 4 reads from the interval sync register
  localparam int SLOT_CTRL = 0;
  localparam int SLOT_CNT = 1;
  localparam int SLOT_PER = 2;
  localparam int SLOT_CMP = 3;
  localparam int SLOT_ICTL = 4;
  localparam int SLOTS = 5;

  // Timing: slow-clock ticks from a write until it takes effect
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  // Top bit of the low-power edge divider that forms the 1 kHz source (divide by 32)
  localparam int LP_DIV_MSB = 4;
  // Tap 0 period is 2^13 slow-clock cycles
  localparam logic [4:0] TAP0_BITS = 5'h0D;

  // Source select codes
  localparam logic [1:0] SRC_LOWPOWER = 2'h0;
  localparam logic [1:0] SRC_LOWPOWER_1K = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL = 2'h2;
  localparam logic [1:0] SRC_EXT_PIN = 2'h3;

  // Register reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [1:0] {
    WB_IDLE = 2'b01,
    WB_ACK = 2'b10
  } rtcpit_wb_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [6:0] adr;
    logic [31:0] dat;
  } rtcpit_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rtcpit_wb_rsp_s;

  typedef struct packed {
    logic wrap_event;
    logic match_event;
    logic [7:0] tap;
  } rtcpit_evt_s;

  typedef struct packed {
    rtcpit_wb_e wb;
    logic [31:0] dat;
    logic [7:0] ctrl_sw;
    logic [7:0] ctrl_act;
    logic [15:0] cnt;
    logic [15:0] cnt_stage;
    logic [15:0] per_stage;
    logic [15:0] per_act;
    logic [15:0] cmp_stage;
    logic [15:0] cmp_act;
    logic [7:0] ictl_sw;
    logic [7:0] ictl_act;
    logic [1:0] irq_en;
    logic [1:0] irq_flg;
    logic int_en;
    logic int_flg;
    logic [7:0] staging;
    logic dbg;
    logic idbg;
    logic [1:0] srcsel;
    logic [SLOTS-1:0] busy;
    logic [2*SLOTS-1:0] scnt;
    logic lp_prev;
    logic [LP_DIV_MSB:0] lp_div;
    logic src_prev;
    logic [14:0] pre;
    logic [14:0] idiv;
    rtcpit_evt_s evt;
  } rtcpit_state_s;

  localparam rtcpit_state_s STATE_RESET = '{wb: WB_IDLE, default: '0};

endpackage
`default_nettype wire

// ---- rtl/rtcpit_top.sv ----
// Real-time counter with periodic interval timer behind a classic Wishbone slave
//
// Implementation choice: the Wishbone register port.
`default_nettype none
module rtcpit_top
  import rtcpit_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Wishbone slave
  input wire rtcpit_pkg::rtcpit_wb_req_s wb_req,
  output rtcpit_pkg::rtcpit_wb_rsp_s wb_rsp,
  // Slow clock sources, sampled on mclk
  input wire logic lowpower_osc,
  input wire logic crystal_osc,
  input wire logic ext_clock_pin,
  // System state
  input wire logic sleep_standby,
  input wire logic debug_halt,
  // Events and interrupt lines
  output rtcpit_pkg::rtcpit_evt_s events,
  output logic counter_irq,
  output logic interval_irq
);
  import rtcpit_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when the low n bits of v are all ones; n of zero is always true
  function automatic logic low_ones(input logic [14:0] v, input logic [4:0] n);
    logic [15:0] mask;
    mask = (16'h0001 << n) - 16'h0001;
    return (v & mask[14:0]) == mask[14:0];
  endfunction

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
    begin
      r[7:0] = d[7:0];
    end
    if (sel[1])
    begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  rtcpit_state_s s_r;
  rtcpit_state_s s_nxt;
  logic step_w;
  logic apply_cnt_w;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic acc;
    logic wr_go;
    logic lo_wr;
    logic [4:0] idx;
    logic [31:0] rd;
    logic src;
    logic tick;
    logic run_cnt;
    logic run_int;
    logic [SLOTS-1:0] apply;
    logic [4:0] pbits;
    logic [1:0] set_flg;
    logic int_set;
    acc = wb_req.cyc && wb_req.stb;
    wr_go = (s_r.wb == WB_ACK) && acc && wb_req.we;
    lo_wr = wr_go && wb_req.sel[0];
    idx = wb_req.adr[6:2];
    rd = 32'h00000000;
    src = 1'b0;
    tick = 1'b0;
    run_cnt = 1'b0;
    run_int = 1'b0;
    apply = '0;
    pbits = 5'h00;
    set_flg = 2'h0;
    int_set = 1'b0;
    step_w = 1'b0;
    apply_cnt_w = 1'b0;
    s_nxt = s_r;
    s_nxt.evt = '0;

    // Read mux
    unique case (idx)
      IDX_MAIN_CONTROL: rd[7:0] = s_r.ctrl_sw;
      IDX_SYNC_BUSY: rd[3:0] = s_r.busy[SLOT_CMP:SLOT_CTRL];
      IDX_IRQ_ENABLE: rd[1:0] = s_r.irq_en;
      IDX_IRQ_FLAGS: rd[1:0] = s_r.irq_flg;
      IDX_STAGING: rd[7:0] = s_r.staging;
      IDX_DEBUG_HALT: rd[0] = s_r.dbg;
      IDX_SOURCE_SELECT: rd[1:0] = s_r.srcsel;
      IDX_TICK_COUNTER: rd[15:0] = s_r.cnt;
      IDX_WRAP_LIMIT: rd[15:0] = s_r.per_stage;
      IDX_MATCH_VALUE: rd[15:0] = s_r.cmp_stage;
      IDX_INTERVAL_CONTROL: rd[7:0] = s_r.ictl_sw;
      IDX_INTERVAL_SYNC: rd[0] = s_r.busy[SLOT_ICTL];
      IDX_INTERVAL_IRQ_EN: rd[0] = s_r.int_en;
      IDX_INTERVAL_FLAG: rd[0] = s_r.int_flg;
      IDX_INTERVAL_DEBUG: rd[0] = s_r.idbg;
      default: rd = 32'h00000000;
    endcase

    // Bus handshake: answer one cycle after the request, then drop
    unique case (s_r.wb)
      WB_IDLE:
      begin
        if (acc)
        begin
          s_nxt.wb = WB_ACK;
          s_nxt.dat = rd;
        end
      end
      WB_ACK:
      begin
        s_nxt.wb = WB_IDLE;
      end
    endcase

    // Slow clock: one selected source for both functions
    s_nxt.lp_prev = lowpower_osc;
    if (lowpower_osc && !s_r.lp_prev)
    begin
      s_nxt.lp_div = s_r.lp_div + 5'h01;
    end
    unique case (s_r.srcsel)
      SRC_LOWPOWER: src = lowpower_osc;
      SRC_LOWPOWER_1K: src = s_r.lp_div[LP_DIV_MSB];
      SRC_CRYSTAL: src = crystal_osc;
      SRC_EXT_PIN: src = ext_clock_pin;
    endcase
    s_nxt.src_prev = src;
    tick = src && !s_r.src_prev;

    // Write crossing: applied on the second slow-clock tick
    for (int i = 0; i < SLOTS; i++)
    begin
      if (tick && s_r.busy[i])
      begin
        if (s_r.scnt[2*i +: 2] == SYNC_TICKS - 2'h1)
        begin
          s_nxt.busy[i] = 1'b0;
          apply[i] = 1'b1;
        end
        else
        begin
          s_nxt.scnt[2*i +: 2] = s_r.scnt[2*i +: 2] + 2'h1;
        end
      end
    end
    if (apply[SLOT_CTRL])
    begin
      s_nxt.ctrl_act = s_r.ctrl_sw;
    end
    if (apply[SLOT_PER])
    begin
      s_nxt.per_act = s_r.per_stage;
    end
    if (apply[SLOT_CMP])
    begin
      s_nxt.cmp_act = s_r.cmp_stage;
    end
    if (apply[SLOT_ICTL])
    begin
      s_nxt.ictl_act = s_r.ictl_sw;
    end

    // Counter with prescaler
    run_cnt = s_r.ctrl_act[CTL_COUNT_ENABLE]
      && !(sleep_standby && !s_r.ctrl_act[CTL_STANDBY_RUN])
      && !(debug_halt && !s_r.dbg);
    if (!s_r.ctrl_act[CTL_COUNT_ENABLE])
    begin
      s_nxt.pre = 15'h0000;
    end
    else if (tick && run_cnt)
    begin
      s_nxt.pre = s_r.pre + 15'h0001;
      if (low_ones(s_r.pre, {1'b0, s_r.ctrl_act[CTL_PRESC_LSB +: 4]}))
      begin
        step_w = 1'b1;
        s_nxt.evt.match_event = s_r.cnt == s_r.cmp_act;
        if (s_r.cnt == s_r.per_act)
        begin
          s_nxt.evt.wrap_event = 1'b1;
          s_nxt.cnt = RST_WORD;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end
      end
    end
    if (apply[SLOT_CNT])
    begin
      apply_cnt_w = 1'b1;
      s_nxt.cnt = s_r.cnt_stage;
    end

    // Interval timer divider chain and taps
    run_int = s_r.ictl_act[ICTL_INTERVAL_ENABLE] && !(debug_halt && !s_r.idbg);
    pbits = {1'b0, s_r.ictl_act[ICTL_PERIOD_LSB +: 4]} + 5'h01;
    if (!s_r.ictl_act[ICTL_INTERVAL_ENABLE])
    begin
      s_nxt.idiv = 15'h0000;
    end
    else if (tick && run_int)
    begin
      s_nxt.idiv = s_r.idiv + 15'h0001;
      for (int k = 0; k < 8; k++)
      begin
        s_nxt.evt.tap[k] = low_ones(s_r.idiv, TAP0_BITS - 5'(k));
      end
      int_set = (pbits != 5'h01) && (pbits != 5'h10) && low_ones(s_r.idiv, pbits);
    end

    // Flags: hardware set wins over software clear
    set_flg[IRQ_WRAP] = s_nxt.evt.wrap_event;
    set_flg[IRQ_MATCH] = s_nxt.evt.match_event;
    s_nxt.irq_flg = s_r.irq_flg | set_flg;
    s_nxt.int_flg = s_r.int_flg | int_set;
    if (lo_wr && idx == IDX_IRQ_FLAGS)
    begin
      s_nxt.irq_flg = (s_r.irq_flg & ~wb_req.dat[1:0]) | set_flg;
    end
    if (lo_wr && idx == IDX_INTERVAL_FLAG && wb_req.dat[0])
    begin
      s_nxt.int_flg = int_set;
    end

    // Register writes
    if (wr_go)
    begin
      unique case (idx)
        IDX_MAIN_CONTROL:
        begin
          if (wb_req.sel[0])
          begin
            s_nxt.ctrl_sw = {wb_req.dat[7:3], 2'h0, wb_req.dat[0]};
            s_nxt.busy[SLOT_CTRL] = 1'b1;
            s_nxt.scnt[2*SLOT_CTRL +: 2] = 2'h0;
          end
        end
        IDX_IRQ_ENABLE: if (wb_req.sel[0]) s_nxt.irq_en = wb_req.dat[1:0];
        IDX_STAGING: if (wb_req.sel[0]) s_nxt.staging = wb_req.dat[7:0];
        IDX_DEBUG_HALT: if (wb_req.sel[0]) s_nxt.dbg = wb_req.dat[DBG_HALT_OVERRIDE];
        IDX_SOURCE_SELECT: if (wb_req.sel[0]) s_nxt.srcsel = wb_req.dat[1:0];
        IDX_TICK_COUNTER:
        begin
          s_nxt.cnt_stage = merge16(s_r.cnt_stage, wb_req.dat, wb_req.sel);
          s_nxt.busy[SLOT_CNT] = 1'b1;
          s_nxt.scnt[2*SLOT_CNT +: 2] = 2'h0;
        end
        IDX_WRAP_LIMIT:
        begin
          s_nxt.per_stage = merge16(s_r.per_stage, wb_req.dat, wb_req.sel);
          s_nxt.busy[SLOT_PER] = 1'b1;
          s_nxt.scnt[2*SLOT_PER +: 2] = 2'h0;
        end
        IDX_MATCH_VALUE:
        begin
          s_nxt.cmp_stage = merge16(s_r.cmp_stage, wb_req.dat, wb_req.sel);
          s_nxt.busy[SLOT_CMP] = 1'b1;
          s_nxt.scnt[2*SLOT_CMP +: 2] = 2'h0;
        end
        IDX_INTERVAL_CONTROL:
        begin
          if (wb_req.sel[0])
          begin
            s_nxt.ictl_sw = {1'b0, wb_req.dat[6:3], 2'h0, wb_req.dat[0]};
            s_nxt.busy[SLOT_ICTL] = 1'b1;
            s_nxt.scnt[2*SLOT_ICTL +: 2] = 2'h0;
          end
        end
        IDX_INTERVAL_IRQ_EN: if (wb_req.sel[0]) s_nxt.int_en = wb_req.dat[0];
        IDX_INTERVAL_DEBUG: if (wb_req.sel[0]) s_nxt.idbg = wb_req.dat[0];
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s_r <= STATE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_rsp.ack = s_r.wb == WB_ACK;
  assign wb_rsp.dat = s_r.dat;
  assign events = s_r.evt;
  assign counter_irq = |(s_r.irq_en & s_r.irq_flg);
  assign interval_irq = s_r.int_en && s_r.int_flg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_WRAP_FLAG: assert property (events.wrap_event |-> s_r.irq_flg[IRQ_WRAP])
    else $error("wrap event without wrap flag");
  AST_WRAP_ZERO: assert property (events.wrap_event && !$past(apply_cnt_w)
                                  |-> s_r.cnt == RST_WORD)
    else $error("counter not zero after wrap");
  AST_MATCH: assert property (events.match_event |-> $past(s_r.cnt == s_r.cmp_act))
    else $error("match event without equal values");
  AST_STEP: assert property (step_w && !apply_cnt_w && s_r.cnt != s_r.per_act
                             |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("counter did not step by one");
  AST_IRQ_LINE: assert property ($rose(s_r.irq_flg[IRQ_MATCH])
                                 && s_r.irq_en[IRQ_MATCH] |-> counter_irq)
    else $error("counter irq missing");
  AST_CTRL_BUSY: assert property ((s_r.wb == WB_ACK) && wb_req.we && wb_req.sel[0]
    && wb_req.adr[6:2] == IDX_MAIN_CONTROL |=> s_r.busy[SLOT_CTRL])
    else $error("control busy not raised");
  AST_INT_BUSY: assert property ((s_r.wb == WB_ACK) && wb_req.we && wb_req.sel[0]
    && wb_req.adr[6:2] == IDX_INTERVAL_CONTROL |=> s_r.busy[SLOT_ICTL])
    else $error("interval busy not raised");
  AST_TAP: assert property (events.tap[7] |-> $past(s_r.idiv[5:0]) == 6'h3F
    && events.tap[6] == $past(s_r.idiv[6]))
    else $error("tap pulse at wrong count");

endmodule
`default_nettype wire
